// ===== logic/uart_lin_autobaud_ctrl.sv
// protocol control, interrupt enables and lin transmit for one uart
// assumes an avalon-mm master and rx_i synchronous to ref_clk_i
//
// Notes on behaviour
// RULE1: wake enable gates the data wake pulse
// RULE2: lin duplex enable turns on break check
// RULE3: break sends 13 low then 1 high
// RULE4: break enable clears after the break field
// RULE5: autobaud enable clears when detection finishes
// RULE6: detection sets done flag, irq if enabled
// RULE7: parity select: 0 odd, 1 even
// RULE8: parity select matters only with parity on
// RULE9: parity on adds a parity bit
// RULE10: stop select gives one or two stops
// RULE11: line status enable raises irq on 7:5
// RULE12: autobaud irq only while enabled
// RULE13: lin break irq only while enabled
// RULE14: interrupt enable register resets to zero
// RULE15: low past 12 bits sets lin break
// RULE16: each measured bit sets done flag
// RULE17: writing one to 7:5 clears all three
// RULE18: parity bit sits between data and stop
// RULE19: interrupt is or of gated flags
`timescale 1ns/1ns
`default_nettype none
module uart_lin_autobaud_ctrl (
   input  wire logic        ref_clk_i,         // 25 MHz clock
   input  wire logic        rstn_i,            // async reset, low
   input  wire logic [7:0]  avs_address_i,     // byte address
   input  wire logic        avs_read_i,        // read request
   input  wire logic        avs_write_i,       // write request
   input  wire logic [31:0] avs_writedata_i,   // write data
   input  wire logic [3:0]  avs_byteenable_i,  // byte lanes
   output logic      [31:0] avs_readdata_o,    // read data
   output logic             avs_waitrequest_o, // stall
   input  wire logic        rx_i,              // serial input
   output logic             tx_o,              // serial output
   input  wire logic [7:0]  tx_data_i,         // word to send
   input  wire logic        tx_valid_i,        // word offered
   output logic             tx_ready_o,        // word taken
   output logic             irq_o,             // level interrupt
   output logic             wake_o             // data wake pulse
);
   import ulac_pkg::*;
   // ==========================================================
   // state
   typedef struct packed {
      logic        ack;      // answer cycle of a request
      logic [31:0] rdata;    // read data
      logic [31:0] ctrl;     // protocol_control
      logic [2:0]  ien;      // protocol_irq_enable
      logic [9:5]  sts;      // sticky flags
      logic [15:0] bp;       // bit period
      ulac_tx_st_t st;       // transmit phase
      logic [15:0] cnt;      // bit timer
      logic [3:0]  bits;     // bits left in phase
      logic [7:0]  sh;       // data shifter
      logic        pbit;     // parity bit of word
      logic        tx;       // line level
      logic        rdy;      // ready for a word
      logic        irq;      // interrupt
      logic        wake;     // wake pulse
   } ulac_core_t;
   ulac_core_t s, n;
   ulac_line_if ln ();
   logic        req;          // any request
   logic        wr;           // write takes effect
   logic [31:0] wdat;         // byte masked write data
   logic [31:0] rd;           // read mux
   logic [9:5]  set;          // flag set events
   logic [9:5]  clr;          // flag clear strobes
   logic        bdone;        // bit time over
   logic [2:0]  cause;        // interrupt sources
   // ==========================================================
   // line monitor
   ulac_rx_mon u_mon (
      .ref_clk_i (ref_clk_i),
      .rstn_i    (rstn_i),
      .rx_i      (rx_i),
      .ln        (ln.mon)
   );
   assign ln.bit_period = s.bp;
   assign ln.parity_on = s.ctrl[CTL_PAR];
   assign ln.even_par = s.ctrl[CTL_EVEN];
   assign ln.two_stop = s.ctrl[CTL_STOP];
   assign ln.lin_rx_en = s.ctrl[CTL_LINRX];
   assign ln.ab_en = s.ctrl[CTL_ABR];
   // ==========================================================
   // next state
   always_comb begin
      n = s;
      req = avs_read_i | avs_write_i;
      wr = avs_write_i & s.ack;
      for (int b = 0; b < 4; b++) begin
         wdat[8*b +: 8] = avs_byteenable_i[b] ? avs_writedata_i[8*b +: 8] : 8'h00;
      end
      // one wait cycle, then the answer; released next edge
      n.ack = req & ~s.ack;
      // read mux, reserved bits read zero
      rd = 32'h0000_0000;
      if (avs_address_i == OFS_CTRL) begin
         rd = s.ctrl;
      end else if (avs_address_i == OFS_IEN) begin
         rd[2:0] = s.ien;
      end else if (avs_address_i == OFS_STS) begin
         rd[9:5] = s.sts;
         rd[STS_BUSY] = ln.rx_busy;
      end else if (avs_address_i == OFS_BAUD) begin
         rd[15:0] = s.bp;
      end
      if (avs_read_i & ~s.ack) n.rdata = rd;
      // software writes; unmapped addresses are ignored
      clr = 5'h00;
      if (wr && avs_address_i == OFS_CTRL) begin
         // plain overwrite so software can clear bits; reserved stay zero
         n.ctrl = wdat & CTRL_WMSK;
         for (int b = 0; b < 4; b++) begin
            if (!avs_byteenable_i[b]) n.ctrl[8*b +: 8] = s.ctrl[8*b +: 8];
         end
      end else if (wr && avs_address_i == OFS_IEN) begin
         if (avs_byteenable_i[0]) n.ien = wdat[2:0];
      end else if (wr && avs_address_i == OFS_STS) begin
         clr[STS_ABD] = wdat[STS_ABD];
         clr[STS_LBRK] = wdat[STS_LBRK];
         clr[7:5] = {3{|wdat[7:5]}};       // [RULE17]
      end else if (wr && avs_address_i == OFS_BAUD) begin
         if (avs_byteenable_i[0]) n.bp[7:0] = wdat[7:0];
         if (avs_byteenable_i[1]) n.bp[15:8] = wdat[15:8];
      end
      // sticky flags, a set wins over a clear in the same cycle
      set = {ln.ab_done, ln.lin_brk, ln.brk, ln.frm_err, ln.par_err};
      n.sts = (s.sts & ~clr) | set;       // [RULE6] [RULE15] [RULE16]
      if (ln.ab_done) n.bp = ln.ab_period;
      if (ln.ab_fin) n.ctrl[CTL_ABR] = 1'b0; // [RULE5]
      // interrupt: each flag gated by its enable
      cause[IEN_RLS] = s.ien[IEN_RLS] & (|s.sts[7:5]); // [RULE11]
      cause[IEN_ABR] = s.ien[IEN_ABR] & s.sts[STS_ABD]; // [RULE12]
      cause[IEN_BRK] = s.ien[IEN_BRK] & s.sts[STS_LBRK]; // [RULE13]
      n.irq = |cause;                     // [RULE19]
      n.wake = s.ctrl[CTL_WAKE] & ln.fall; // [RULE1]
      // transmitter
      bdone = (s.cnt == 16'h0000);
      if (s.st != T_IDLE) n.cnt = bdone ? s.bp - 16'h0001 : s.cnt - 16'h0001;
      case (s.st)
         T_IDLE: begin
            n.cnt = s.bp - 16'h0001;
            if (tx_valid_i && s.rdy) begin
               n.sh = tx_data_i;
               n.pbit = ^tx_data_i ^ ~s.ctrl[CTL_EVEN]; // [RULE7]
               if (s.ctrl[CTL_LINBRK]) begin
                  n.st = T_BRK;
                  n.bits = TX_BRK_BITS - 4'h1;  // [RULE3]
               end else begin
                  n.st = T_START;
               end
            end
         end
         T_BRK: begin
            if (bdone) begin
               n.bits = s.bits - 4'h1;
               if (s.bits == 4'h0) n.st = T_DELIM;
            end
         end
         T_DELIM: begin
            if (bdone) begin
               n.st = T_START;
               n.ctrl[CTL_LINBRK] = 1'b0;       // [RULE4]
            end
         end
         T_START: begin
            if (bdone) begin
               n.st = T_DATA;
               n.bits = 4'h7;
            end
         end
         T_DATA: begin
            if (bdone) begin
               n.sh = {1'b0, s.sh[7:1]};
               n.bits = s.bits - 4'h1;
               if (s.bits == 4'h0) begin
                  n.st = s.ctrl[CTL_PAR] ? T_PAR : T_STOP; // [RULE8] [RULE9] [RULE18]
                  n.bits = {3'h0, s.ctrl[CTL_STOP]};       // [RULE10]
               end
            end
         end
         T_PAR: begin
            if (bdone) n.st = T_STOP;
         end
         default: begin
            if (bdone) begin
               n.bits = s.bits - 4'h1;
               if (s.bits == 4'h0) n.st = T_IDLE;
            end
         end
      endcase
      case (n.st)
         T_BRK, T_START: n.tx = 1'b0;
         T_DATA: n.tx = n.sh[0];
         T_PAR: n.tx = n.pbit;
         default: n.tx = 1'b1;
      endcase
      n.rdy = (n.st == T_IDLE) && !(tx_valid_i && s.rdy);
   end
   // ==========================================================
   // registers
   always_ff @(posedge ref_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         s <= '0;
         s.ctrl <= CTRL_RST;
         s.ien <= IEN_RST;                // [RULE14]
         s.bp <= BIT_CLKS;
         s.st <= T_IDLE;
         s.tx <= 1'b1;
         s.rdy <= 1'b1;
      end else begin
         s <= n;
      end
   end
   assign avs_readdata_o = s.rdata;
   assign avs_waitrequest_o = ~s.ack;
   assign tx_o = s.tx;
   assign tx_ready_o = s.rdy;
   assign irq_o = s.irq;
   assign wake_o = s.wake;
   // ==========================================================
   // checks
   logic [31:0] lo_run;               // cycles spent in break
   always_ff @(posedge ref_clk_i or negedge rstn_i) begin
      if (!rstn_i) lo_run <= 32'h0000_0000;
      else if (s.st == T_BRK) lo_run <= lo_run + 32'h0000_0001;
      else lo_run <= 32'h0000_0000;
   end
   sequence seq_brk_end;
      (s.st == T_BRK) ##1 (s.st == T_DELIM);
   endsequence
   sequence seq_delim_end;
      (s.st == T_DELIM) ##1 (s.st == T_START);
   endsequence
   chk_ien_reset: assert property (@(posedge ref_clk_i) $rose(rstn_i) |-> s.ien == 3'h0) // [RULE14]
      else $error("enable register not zero after reset");
   chk_brk_length: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
      seq_brk_end |-> $past(lo_run) + 32'h1 == 32'(TX_BRK_BITS) * 32'(s.bp)) // [RULE3]
      else $error("break field not 13 bit times");
   chk_brk_level: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
      (s.st == T_BRK) |-> !tx_o) // [RULE3]
      else $error("line high during break");
   chk_delim_high: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
      (s.st == T_DELIM) |-> tx_o) // [RULE3]
      else $error("delimiter not high");
   chk_brk_autoclr: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
      seq_delim_end |-> !s.ctrl[CTL_LINBRK]) // [RULE4]
      else $error("break enable not cleared");
   chk_abr_autoclr: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
      ln.ab_fin |=> !s.ctrl[CTL_ABR]) // [RULE5]
      else $error("autobaud enable not cleared");
   chk_abd_flag: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
      ln.ab_done |=> s.sts[STS_ABD]) // [RULE6]
      else $error("autobaud done flag not set");
   chk_lbrk_irq: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
      ln.lin_brk && s.ien[IEN_BRK] && !req && !s.ack |-> ##2 irq_o) // [RULE13]
      else $error("lin break interrupt missing");
   chk_irq_masked: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
      (s.ien == 3'h0) |=> !irq_o) // [RULE12]
      else $error("interrupt while all enables off");
   chk_bus_answer: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
      req && avs_waitrequest_o |=> !avs_waitrequest_o ##1 avs_waitrequest_o)
      else $error("bus answer not one cycle");
endmodule
`default_nettype wire

// ===== logic/ulac_line_if.sv
// carrier between the register core and the receive line monitor
// assumes both ends share ref_clk_i
`timescale 1ns/1ns
`default_nettype none
interface ulac_line_if;
   logic [15:0] bit_period; // clocks per bit
   logic        parity_on;  // parity bit in frame
   logic        even_par;   // even parity when high
   logic        two_stop;   // two stop bits
   logic        lin_rx_en;  // lin slave break check
   logic        ab_en;      // autobaud running
   logic        frm_err;    // pulse: bad stop bit
   logic        par_err;    // pulse: bad parity
   logic        brk;        // pulse: low past a word
   logic        lin_brk;    // pulse: low past 12 bits
   logic        ab_done;    // pulse: one bit measured
   logic        ab_fin;     // pulse: detection over
   logic        rx_busy;    // receiver in a frame
   logic        fall;       // pulse: rx falling edge
   logic [15:0] ab_period;  // measured bit period
   modport ctrl (output bit_period, parity_on, even_par, two_stop,
                 lin_rx_en, ab_en, input frm_err, par_err, brk,
                 lin_brk, ab_done, ab_fin, rx_busy, fall, ab_period);
   modport mon (input bit_period, parity_on, even_par, two_stop,
                lin_rx_en, ab_en, output frm_err, par_err, brk,
                lin_brk, ab_done, ab_fin, rx_busy, fall, ab_period);
endinterface
`default_nettype wire

// ===== logic/ulac_pkg.sv
// constants and types shared by the protocol control block
// assumes one 25 MHz clock and byte addressed avalon registers
package ulac_pkg;
   // ==========================================================
   // register map (byte addresses)
   localparam logic [7:0]  OFS_CTRL = 8'h5C;   // protocol_control
   localparam logic [7:0]  OFS_IEN  = 8'h60;   // protocol_irq_enable
   localparam logic [7:0]  OFS_STS  = 8'h64;   // protocol_status
   localparam logic [7:0]  OFS_BAUD = 8'h68;   // bit period in clocks
   localparam logic [31:0] CTRL_RST = 32'h0000_0000;
   localparam logic [31:0] CTRL_WMSK = 32'h0000_03C7;
   localparam logic [2:0]  IEN_RST  = 3'h0;
   // ==========================================================
   // field positions
   localparam int CTL_WAKE = 9;   // data_wake_enable
   localparam int CTL_LINRX = 8;  // lin_rx_duplex_enable
   localparam int CTL_LINBRK = 7; // lin_tx_break_enable
   localparam int CTL_ABR = 6;    // autobaud_detect_enable
   localparam int CTL_EVEN = 2;   // even_odd_parity_select
   localparam int CTL_PAR = 1;    // parity_bit_on
   localparam int CTL_STOP = 0;   // stop_bit_count_select
   localparam int IEN_RLS = 2;    // rx_line_status_irq_enable
   localparam int IEN_ABR = 1;    // autobaud_irq_enable
   localparam int IEN_BRK = 0;    // lin_break_irq_enable
   localparam int STS_BUSY = 10;  // receiver busy, read only
   localparam int STS_ABD = 9;    // autobaud_done_flag
   localparam int STS_LBRK = 8;   // lin_break_seen_flag
   localparam int STS_BRK = 7;    // line break flag
   localparam int STS_FRM = 6;    // framing_error_flag
   localparam int STS_PERR = 5;   // parity_error_flag
   // ==========================================================
   // timing
   localparam int CLK_HZ = 25_000_000;
   localparam int BAUD_DEF = 115_200;
   localparam logic [15:0] BIT_CLKS = 16'(CLK_HZ / BAUD_DEF);
   localparam logic [3:0]  TX_BRK_BITS = 4'hD;  // 13 low bits
   localparam logic [4:0]  RX_LBRK_BITS = 5'h0C; // 12 low bits
   localparam logic [2:0]  AB_LAST = 3'h3;      // 4 detections
   typedef enum logic [2:0] {T_IDLE, T_BRK, T_DELIM, T_START, T_DATA,
                             T_PAR, T_STOP} ulac_tx_st_t;
   typedef enum logic [2:0] {R_IDLE, R_START, R_DATA, R_PAR,
                             R_STOP} ulac_rx_st_t;
endpackage

// ===== logic/ulac_rx_mon.sv
// receive line monitor: frame checker, break and autobaud timing
// assumes rx_i is already synchronous to ref_clk_i
`timescale 1ns/1ns
`default_nettype none
module ulac_rx_mon (
   input  wire logic ref_clk_i, // functional clock
   input  wire logic rstn_i,    // async reset, low
   input  wire logic rx_i,      // serial input
   ulac_line_if.mon  ln         // config in, events out
);
   import ulac_pkg::*;
   // ==========================================================
   // state
   typedef struct packed {
      logic        rx_q;                 // last rx sample
      ulac_rx_st_t st;                   // receiver phase
      logic [15:0] cnt;                  // bit timer
      logic [3:0]  bits;                 // bits left
      logic        pacc;                 // parity of data
      logic [15:0] low_clk;              // low time in bit
      logic [4:0]  low_bits;             // whole low bits
      logic        arm;                  // autobaud armed
      logic [2:0]  ab_n;                 // detections so far
      logic [16:0] ab_iv;                // edge interval
      logic        fe, pe, brk, lbrk, abd, abf, busy, fall;
      logic [15:0] ab_per;               // measured period
   } ulac_mon_t;
   ulac_mon_t s, n;
   logic [4:0] word_bits;               // start+data+par+stops
   logic       fell;                    // falling edge seen
   // ==========================================================
   // next state
   always_comb begin
      n = s;
      n.rx_q = rx_i;
      {n.fe, n.pe, n.brk, n.lbrk, n.abd, n.abf} = 6'h00;
      fell = s.rx_q & ~rx_i;
      n.fall = fell;
      word_bits = 5'h0A + {4'h0, ln.parity_on} + {4'h0, ln.two_stop};
      // low duration, counted in whole bits, saturating
      if (rx_i) begin
         n.low_clk = 16'h0000;
         n.low_bits = 5'h00;
      end else if (s.low_clk == ln.bit_period - 16'h0001) begin
         n.low_clk = 16'h0000;
         if (s.low_bits != 5'h1F) n.low_bits = s.low_bits + 5'h01;
      end else begin
         n.low_clk = s.low_clk + 16'h0001;
      end
      // one pulse when low has just outlasted the limit
      if (!rx_i && s.low_clk == 16'h0000 && s.low_bits != 5'h00) begin
         n.brk = (s.low_bits == word_bits);
         n.lbrk = ln.lin_rx_en && (s.low_bits == RX_LBRK_BITS); // [RULE2] [RULE15]
      end
      // frame receiver, sampling mid bit
      case (s.st)
         R_IDLE: begin
            if (fell) begin
               n.st = R_START;
               n.cnt = ln.bit_period >> 1;
            end
         end
         R_START: begin
            if (s.cnt != 16'h0000) n.cnt = s.cnt - 16'h0001;
            else if (rx_i) n.st = R_IDLE; // glitch, not a start
            else begin
               n.st = R_DATA;
               n.cnt = ln.bit_period - 16'h0001;
               n.bits = 4'h7;
               n.pacc = 1'b0;
            end
         end
         R_DATA: begin
            if (s.cnt != 16'h0000) n.cnt = s.cnt - 16'h0001;
            else begin
               n.cnt = ln.bit_period - 16'h0001;
               n.pacc = s.pacc ^ rx_i;
               n.bits = s.bits - 4'h1;
               if (s.bits == 4'h0) begin
                  n.st = ln.parity_on ? R_PAR : R_STOP; // [RULE9] [RULE18]
                  n.bits = {3'h0, ln.two_stop};          // [RULE10]
               end
            end
         end
         R_PAR: begin
            if (s.cnt != 16'h0000) n.cnt = s.cnt - 16'h0001;
            else begin
               n.cnt = ln.bit_period - 16'h0001;
               n.pe = s.pacc ^ rx_i ^ ~ln.even_par; // [RULE7] [RULE8]
               n.st = R_STOP;
            end
         end
         default: begin
            if (s.cnt != 16'h0000) n.cnt = s.cnt - 16'h0001;
            else begin
               n.cnt = ln.bit_period - 16'h0001;
               n.fe = ~rx_i;
               n.bits = s.bits - 4'h1;
               if (s.bits == 4'h0) n.st = R_IDLE;
            end
         end
      endcase
      n.busy = (n.st != R_IDLE);
      // autobaud: measure between falling edges of a 0x55 pattern
      if (s.ab_iv != 17'h1FFFF) n.ab_iv = s.ab_iv + 17'h00001;
      if (!ln.ab_en) begin
         n.arm = 1'b0;
         n.ab_n = 3'h0;
      end else if (fell) begin
         n.ab_iv = 17'h00001;
         n.arm = 1'b1;
         if (s.arm) begin
            n.abd = 1'b1;                      // [RULE16]
            n.ab_per = s.ab_iv[16:1];          // two bits per interval
            n.ab_n = s.ab_n + 3'h1;
            if (s.ab_n == AB_LAST) begin
               n.abf = 1'b1;                   // [RULE5]
               n.arm = 1'b0;
            end
         end
      end
   end
   // ==========================================================
   // registers
   always_ff @(posedge ref_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         s <= '0;
         s.rx_q <= 1'b1;
      end else begin
         s <= n;
      end
   end
   assign ln.frm_err = s.fe;
   assign ln.par_err = s.pe;
   assign ln.brk = s.brk;
   assign ln.lin_brk = s.lbrk;
   assign ln.ab_done = s.abd;
   assign ln.ab_fin = s.abf;
   assign ln.rx_busy = s.busy;
   assign ln.fall = s.fall;
   assign ln.ab_period = s.ab_per;
endmodule
`default_nettype wire

// ===== testbench/tb_uart_lin_autobaud_ctrl.sv
// self-checking bench: avalon register access, tx framing, rx events
// assumes the node model drives rx_i and the bench samples tx_o
`timescale 1ns/1ns
`default_nettype none
`define CHK(n, e, s) begin tests_run++; if ((s) !== (e)) begin fails++; \
   $display("mismatch %s exp %0h got %0h", n, e, s); end end
module tb_uart_lin_autobaud_ctrl;
   import ulac_pkg::*;
   localparam int BP = 8; // short bit period keeps the run brief
   logic        ref_clk_i, rstn_i, rd, wr, tv, txo, tr, irq, wk_p, rx, wt;
   logic [7:0]  adr, td;
   logic [31:0] wd, rdat, q;
   logic [15:0] smp;       // tx_o samples at mid bit
   int          fails, tests_run, lowc, wkc, off;
   // ==========================================================
   // clock, design and far side
   initial begin
      ref_clk_i = 1'b0;
      forever #20 ref_clk_i = ~ref_clk_i;
   end
   uart_lin_autobaud_ctrl i_dut (.ref_clk_i(ref_clk_i), .rstn_i(rstn_i),
      .avs_address_i(adr), .avs_read_i(rd), .avs_write_i(wr),
      .avs_writedata_i(wd), .avs_byteenable_i(4'hF), .avs_readdata_o(rdat),
      .avs_waitrequest_o(wt), .rx_i(rx), .tx_o(txo), .tx_data_i(td),
      .tx_valid_i(tv), .tx_ready_o(tr), .irq_o(irq), .wake_o(wk_p));
   ulac_node i_node (.ref_clk_i(ref_clk_i), .rx_o(rx));
   // busy cycles and wake pulses, counted at the sampling edge
   always @(posedge ref_clk_i) begin
      if (tr === 1'b0) lowc++;
      if (wk_p === 1'b1) wkc++;
   end
   // ==========================================================
   // tasks
   // one avalon transfer, held until waitrequest is seen low
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge ref_clk_i);
      adr <= a;
      wr <= w;
      rd <= !w;
      wd <= d;
      // waitrequest and read data are looked at on the same rising edge
      do @(posedge ref_clk_i); while (wt !== 1'b0);
      q = rdat;
      rd <= 1'b0;
      wr <= 1'b0;
   endtask
   // offer one word, sample 16 bit times, measure busy length
   task automatic txw(input logic [7:0] d);
      int s;
      @(posedge ref_clk_i);
      td <= d;
      tv <= 1'b1;
      do @(negedge ref_clk_i); while (tr !== 1'b1);
      s = lowc;
      @(posedge ref_clk_i);
      tv <= 1'b0;
      repeat (1 + BP / 2) @(negedge ref_clk_i);
      for (int i = 0; i < 16; i++) begin
         smp[i] = txo;
         repeat (BP) @(negedge ref_clk_i);
      end
      while (tr !== 1'b1) @(negedge ref_clk_i);
      off = lowc - s;
   endtask
   task automatic results;
      $display("checks %0d mismatches %0d", tests_run, fails);
      if (fails == 0 && tests_run > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   // hang guard, far beyond the roughly 1300 cycles needed
   initial begin
      repeat (20000) @(posedge ref_clk_i);
      fails++;
      results;
   end
   // ==========================================================
   // main sequence
   initial begin
      int n, base;
      logic [15:0] e;
      logic [31:0] cf [3];
      cf = '{32'h7, 32'h2, 32'h4}; // 8e2, 8o1, parity off 8n1
      {rstn_i, rd, wr, tv, adr, td, wd} = '0;
      {fails, tests_run, lowc, wkc} = '0;
      repeat (4) @(posedge ref_clk_i);
      rstn_i <= 1'b1;
      bus(1'b0, OFS_IEN, 32'h0); `CHK("ien reset", 32'h0, q)
      bus(1'b0, 8'h70, 32'h0); `CHK("unmapped", 32'h0, q)
      bus(1'b1, OFS_CTRL, 32'hFFFF_FFFF);
      bus(1'b0, OFS_CTRL, 32'h0); `CHK("ctrl bits", CTRL_WMSK, q)
      bus(1'b1, OFS_BAUD, 32'(BP));
      // frame format: parity bit place and sense, stop count by length
      for (int c = 0; c < 3; c++) begin
         bus(1'b1, OFS_CTRL, cf[c]);
         txw(8'hA5);
         e = 16'hFFFF;
         e[0] = 1'b0;
         e[8:1] = 8'hA5;
         if (cf[c][1]) e[9] = cf[c][2] ? ^8'hA5 : ~^8'hA5;
         `CHK("tx frame", e, smp)
         n = 10 + int'(cf[c][1]) + int'(cf[c][0]);
         if (c == 0) base = off - n * BP;
         `CHK("tx length", base, off - n * BP)
      end
      bus(1'b1, OFS_CTRL, 32'h80);
      txw(8'hFF); `CHK("break field", 16'hA000, smp)
      bus(1'b0, OFS_CTRL, 32'h0); `CHK("break self clear", 32'h0, q)
      // received parity, line status interrupt, shared clear
      bus(1'b1, OFS_CTRL, 32'h6);
      bus(1'b1, OFS_IEN, 32'h4);
      i_node.send(8'hA5, 1'b1, 1'b1, 1, BP); // even sense wants a zero here
      bus(1'b0, OFS_STS, 32'h0); `CHK("parity error", 1'b1, q[STS_PERR])
      @(negedge ref_clk_i); `CHK("line irq", 1'b1, irq)
      bus(1'b1, OFS_STS, 32'h80);
      bus(1'b0, OFS_STS, 32'h0); `CHK("line clear", 3'h0, q[7:5])
      bus(1'b1, OFS_CTRL, 32'h2);
      i_node.send(8'hA5, 1'b1, 1'b1, 1, BP);
      bus(1'b1, OFS_CTRL, 32'h4);
      i_node.send(8'hA5, 1'b0, 1'b0, 1, BP);
      bus(1'b0, OFS_STS, 32'h0); `CHK("clean frames", 3'h0, q[7:5])
      `CHK("wake off", 0, wkc)
      // lin slave break detection
      bus(1'b1, OFS_IEN, 32'h1);
      bus(1'b1, OFS_CTRL, 32'h100);
      i_node.hold_low(13 * BP);
      bus(1'b0, OFS_STS, 32'h0); `CHK("lin break", 1'b1, q[STS_LBRK])
      @(negedge ref_clk_i); `CHK("break irq", 1'b1, irq)
      // autobaud on a 0x55 word at another rate, wake pulses alongside
      bus(1'b1, OFS_STS, 32'h3E0);
      bus(1'b1, OFS_IEN, 32'h2);
      bus(1'b1, OFS_CTRL, 32'h240);
      @(negedge ref_clk_i);
      wkc = 0;
      i_node.send(8'h55, 1'b0, 1'b0, 1, 12);
      `CHK("wake pulses", 5, wkc)
      bus(1'b0, OFS_CTRL, 32'h0); `CHK("autobaud clear", 1'b0, q[CTL_ABR])
      bus(1'b0, OFS_BAUD, 32'h0); `CHK("period", 16'h000C, q[15:0])
      bus(1'b0, OFS_STS, 32'h0); `CHK("autobaud done", 1'b1, q[STS_ABD])
      @(negedge ref_clk_i); `CHK("autobaud irq", 1'b1, irq)
      bus(1'b1, OFS_STS, 32'h3E0);
      bus(1'b1, OFS_IEN, 32'h0);
      bus(1'b1, OFS_CTRL, 32'h40);
      i_node.send(8'h55, 1'b0, 1'b0, 1, 12);
      @(negedge ref_clk_i); `CHK("autobaud masked", 1'b0, irq)
      bus(1'b1, OFS_IEN, 32'h2);
      repeat (2) @(negedge ref_clk_i); `CHK("autobaud unmasked", 1'b1, irq)
      bus(1'b1, OFS_STS, 32'h200);
      repeat (2) @(negedge ref_clk_i); `CHK("irq cleared", 1'b0, irq)
      results;
   end
endmodule
`default_nettype wire

// ===== testbench/ulac_node.sv
// far-side node model: drives the serial line into the block
// assumes it shares ref_clk_i and that the line idles high
`timescale 1ns/1ns
`default_nettype none
module ulac_node (
   input  wire logic ref_clk_i, // functional clock
   output logic      rx_o       // serial line into the block
);
   // ==========================================================
   // line driver
   initial rx_o = 1'b1; // idle high, as the pull-up leaves it
   // hold one level for n clocks, changed just after an edge
   task automatic lvl(input logic b, input int n);
      rx_o <= b;
      repeat (n) @(posedge ref_clk_i);
   endtask
   // one word, lsb first, optional parity bit, then stops
   task automatic send(input logic [7:0] d, input logic pe, input logic pv,
                       input int ns, input int bp);
      @(posedge ref_clk_i);
      lvl(1'b0, bp);
      for (int i = 0; i < 8; i++) lvl(d[i], bp);
      if (pe) lvl(pv, bp);
      lvl(1'b1, bp * ns);
   endtask
   // long low level, then back to idle
   task automatic hold_low(input int n);
      @(posedge ref_clk_i);
      lvl(1'b0, n);
      lvl(1'b1, 16);
   endtask
endmodule
`default_nettype wire
